/* rcadc_counters.sv */
// Top of the RC-oscillation converter counting core.
`timescale 1ns/1ps
module rcadc_counters (
	input  wire logic                       core_clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       base_tick_clock_i,
	input  wire logic                       rc_osc_clock_i,
	input  wire logic                       ref_counter_select_i,
	input  wire logic [rcadc_pkg::MODE_W-1:0] osc_mode_field_i,
	input  wire logic                       conv_run_set_i,
	input  wire logic                       conv_run_clear_i,
	input  wire logic                       counter_a_load_i,
	input  wire logic [rcadc_pkg::CNT_W-1:0]  counter_a_preset_i,
	input  wire logic                       counter_b_load_i,
	input  wire logic [rcadc_pkg::CNT_W-1:0]  counter_b_preset_i,
	output logic                            conv_run_bit_o,
	output logic                            gate_enable_sync_o,
	output logic                            conv_done_request_o,
	output logic [rcadc_pkg::CNT_W-1:0]       counter_a_value_o,
	output logic [rcadc_pkg::CNT_W-1:0]       counter_b_value_o,
	output logic                            osc_channel0_en_o,
	output logic                            osc_channel1_en_o,
	output logic                            mode_prohibited_o
);
	typedef struct packed {
		logic                        run;
		logic                        gate;
		logic                        irq;
		logic [rcadc_pkg::CNT_W-1:0] cnt_a;
		logic [rcadc_pkg::CNT_W-1:0] cnt_b;
		logic                        osc0;
		logic                        osc1;
		logic                        bad_mode;
		logic                        ref_sel;
	} rcadc_state_t;

	rcadc_state_t st;
	rcadc_state_t next_st;
	rcadc_sync_if ev ();

	rcadc_edge_sync u_sync (
		.core_clk_i        (core_clk_i),
		.reset_n_i         (reset_n_i),
		.base_tick_clock_i (base_tick_clock_i),
		.rc_osc_clock_i    (rc_osc_clock_i),
		.ev                (ev)
	);

	// Carry-extended sums show an overflow in the same cycle as the wrap.
	logic                        a_tick;
	logic                        b_tick;
	logic [rcadc_pkg::CNT_W:0]   a_sum;
	logic [rcadc_pkg::CNT_W:0]   b_sum;

	logic                        ovf;
	logic                        mode_bad;
	logic                        start_ok;

	// Adds one edge to a counter; the extra top bit is the carry out of the wrap.
	function automatic logic [rcadc_pkg::CNT_W:0] count_step(
		input logic [rcadc_pkg::CNT_W-1:0] value,
		input logic                        tick
	);
		logic [rcadc_pkg::CNT_W:0] wide;
		wide = {1'b0, value};
		if (tick) begin
			wide = wide + {{rcadc_pkg::CNT_W{1'b0}}, 1'b1};
		end
		return wide;
	endfunction : count_step

	// Only the carry of the reference counter may end a conversion.
	function automatic logic ref_overflow(
		input logic                      sel,
		input logic [rcadc_pkg::CNT_W:0] a_wide,
		input logic [rcadc_pkg::CNT_W:0] b_wide
	);
		logic carry;
		if (sel) begin
			carry = b_wide[rcadc_pkg::CNT_W];
		end else begin
			carry = a_wide[rcadc_pkg::CNT_W];
		end
		return carry;
	endfunction : ref_overflow

	function automatic logic mode_is_prohibited(
		input logic [rcadc_pkg::MODE_W-1:0] mode
	);
		return mode[rcadc_pkg::MODE_TOP_BIT];
	endfunction : mode_is_prohibited

	// External-clock modes feed the counter from a pin and run no on-chip oscillator.
	function automatic logic mode_is_ext(
		input logic [rcadc_pkg::MODE_W-1:0] mode
	);
		logic ext;
		ext = 1'b0;
		if (mode == rcadc_pkg::MODE_EXT0) begin
			ext = 1'b1;
		end else if (mode == rcadc_pkg::MODE_EXT1) begin
			ext = 1'b1;
		end
		return ext;
	endfunction : mode_is_ext

	function automatic logic mode_uses_ch1(
		input logic [rcadc_pkg::MODE_W-1:0] mode
	);
		return mode >= rcadc_pkg::MODE_CH1_FIRST;
	endfunction : mode_uses_ch1

	// One channel at most oscillates, so the two never disturb each other.
	function automatic logic chan_enable(
		input logic [rcadc_pkg::MODE_W-1:0] mode,
		input logic                         gate,
		input logic                         ch1
	);
		logic en;
		en = 1'b0;
		if (gate && !mode_is_ext(mode) && !mode_is_prohibited(mode)) begin
			en = (mode_uses_ch1(mode) == ch1);
		end
		return en;
	endfunction : chan_enable

	// The gate opens only on a synchronised base-clock fall while running.
	function automatic logic gate_opens(
		input logic run,
		input logic gate,
		input logic fall
	);
		return run && !gate && fall;
	endfunction : gate_opens

	// A preset is refused while running, so software cannot disturb a gate in progress.
	function automatic logic [rcadc_pkg::CNT_W-1:0] load_or_keep(
		input logic                        run,
		input logic                        load,
		input logic [rcadc_pkg::CNT_W-1:0] preset,
		input logic [rcadc_pkg::CNT_W-1:0] kept
	);
		logic [rcadc_pkg::CNT_W-1:0] value;
		value = kept;
		if (!run && load) begin
			value = preset;
		end
		return value;
	endfunction : load_or_keep

	always_comb begin
		a_tick   = st.gate & ev.base_fall;
		b_tick   = st.gate & ev.rc_rise;
		a_sum    = count_step(st.cnt_a, a_tick);
		b_sum    = count_step(st.cnt_b, b_tick);

		ovf      = ref_overflow(st.ref_sel, a_sum, b_sum);
		mode_bad = mode_is_prohibited(osc_mode_field_i);
		start_ok = conv_run_set_i && !st.run && !mode_bad;

		next_st          = st;
		next_st.irq      = 1'b0;
		next_st.bad_mode = mode_bad;

		// Counter values wrap to zero on overflow, so the reference counter reads zero when the conversion ends.
		next_st.cnt_a    = a_sum[rcadc_pkg::CNT_W-1:0];
		next_st.cnt_b    = b_sum[rcadc_pkg::CNT_W-1:0];

		if (gate_opens(st.run, st.gate, ev.base_fall)) begin
			next_st.gate = 1'b1;
		end

		// Overflow outranks a software stop, and a stop outranks a start.
		if (st.gate && ovf) begin
			next_st.run  = 1'b0;
			next_st.gate = 1'b0;
			next_st.irq  = 1'b1;
		end else if (conv_run_clear_i) begin
			next_st.run  = 1'b0;
			next_st.gate = 1'b0;
		end else if (start_ok) begin
			next_st.run  = 1'b1;
			// The reference is latched at start so a late write cannot move the stop.
			next_st.ref_sel = ref_counter_select_i;
		end

		next_st.cnt_a = load_or_keep(st.run, counter_a_load_i,
		                             counter_a_preset_i, next_st.cnt_a);
		next_st.cnt_b = load_or_keep(st.run, counter_b_load_i,
		                             counter_b_preset_i, next_st.cnt_b);

		next_st.osc0 = chan_enable(osc_mode_field_i, next_st.gate, 1'b0);
		next_st.osc1 = chan_enable(osc_mode_field_i, next_st.gate, 1'b1);
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st.run      <= 1'b0;
			st.gate     <= 1'b0;
			st.irq      <= 1'b0;
			st.cnt_a    <= rcadc_pkg::CNT_RESET;
			st.cnt_b    <= rcadc_pkg::CNT_RESET;
			st.osc0     <= 1'b0;
			st.osc1     <= 1'b0;
			st.bad_mode <= 1'b0;
			st.ref_sel  <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Every output is a register bit, so no decode glitch reaches the pins.
	assign conv_run_bit_o      = st.run;
	assign gate_enable_sync_o  = st.gate;
	assign conv_done_request_o = st.irq;

	assign counter_a_value_o   = st.cnt_a;
	assign counter_b_value_o   = st.cnt_b;

	assign osc_channel0_en_o   = st.osc0;
	assign osc_channel1_en_o   = st.osc1;
	assign mode_prohibited_o   = st.bad_mode;
endmodule : rcadc_counters

/* rcadc_pkg.sv */
// Package of constants for the RC-oscillation ratio converter counters.
package rcadc_pkg;
	localparam int CNT_W = 24;
	localparam int MODE_W = 4;
	localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
	localparam int MODE_TOP_BIT = 3;
	localparam logic [MODE_W-1:0] MODE_CH1_FIRST = 4'h5;
	localparam logic [MODE_W-1:0] MODE_EXT0 = 4'h0;
	localparam logic [MODE_W-1:0] MODE_EXT1 = 4'h7;
	localparam int CLK_PERIOD_NS = 10;
endpackage : rcadc_pkg

/* rcadc_sync_if.sv */
// Interface carrying synchronised edge events from the pin synchroniser.
`timescale 1ns/1ps
interface rcadc_sync_if;
	logic base_fall;
	logic rc_rise;
	modport src (output base_fall, output rc_rise);
	modport dst (input base_fall, input rc_rise);
endinterface : rcadc_sync_if

/* rcadc_edge_sync.sv */
// Three-flop synchronisers and edge detection for the two external clocks.
`timescale 1ns/1ps
module rcadc_edge_sync (
	input  wire logic  core_clk_i,
	input  wire logic  reset_n_i,
	input  wire logic  base_tick_clock_i,
	input  wire logic  rc_osc_clock_i,
	rcadc_sync_if.src  ev
);
	typedef struct packed {
		logic [2:0] base;
		logic [2:0] rc;
		logic       base_lvl;
		logic       rc_lvl;
		logic       base_fall;
		logic       rc_rise;
	} rcadc_sync_state_t;

	rcadc_sync_state_t st;
	rcadc_sync_state_t next_st;

	// A change counts once the second and third stages agree; the first feeds only the second.
	always_comb begin
		next_st           = st;
		next_st.base      = {st.base[1:0], base_tick_clock_i};
		next_st.rc        = {st.rc[1:0], rc_osc_clock_i};
		next_st.base_lvl  = (st.base[1] == st.base[2]) ? st.base[2] : st.base_lvl;
		next_st.rc_lvl    = (st.rc[1] == st.rc[2]) ? st.rc[2] : st.rc_lvl;
		next_st.base_fall = st.base_lvl & ~st.base[1] & ~st.base[2];
		next_st.rc_rise   = ~st.rc_lvl & st.rc[1] & st.rc[2];
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ev.base_fall = st.base_fall;
	assign ev.rc_rise   = st.rc_rise;
endmodule : rcadc_edge_sync

/* rcadc_osc_model.sv */
// Behavioural RC oscillator that stands at the far side of the converter.
`timescale 1ns/1ps
module rcadc_osc_model #(parameter int HALF_NS = 30) (
	input  wire logic en_i,
	output logic      clk_o
);
	initial clk_o = 1'b0;
	// A stopped oscillator rests low, so no stale edge leaks into the next gate.
	always begin
		wait (en_i);
		#HALF_NS clk_o = ~clk_o;
		if (!en_i) clk_o = 1'b0;
	end
endmodule : rcadc_osc_model

/* rcadc_counters_chk.sv */
// Assertion checker for the converter counting core.
`timescale 1ns/1ps
module rcadc_counters_chk (
	input wire logic        core_clk_i,
	input wire logic        reset_n_i,
	input wire logic        ref_counter_select_i,
	input wire logic [3:0]  osc_mode_field_i,
	input wire logic        conv_run_set_i,
	input wire logic        conv_run_clear_i,
	input wire logic        counter_a_load_i,
	input wire logic        conv_run_bit_o,
	input wire logic        gate_enable_sync_o,
	input wire logic        conv_done_request_o,
	input wire logic [23:0] counter_a_value_o,
	input wire logic [23:0] counter_b_value_o,
	input wire logic        osc_channel0_en_o,
	input wire logic        osc_channel1_en_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_idle; !conv_run_bit_o && !gate_enable_sync_o; endsequence
	a_run_start: assert property (!conv_run_bit_o && conv_run_set_i && !conv_run_clear_i
		&& !osc_mode_field_i[3] |=> conv_run_bit_o) else $error("run not taken");
	a_mode_refused: assert property (osc_mode_field_i[3] && !conv_run_bit_o
		|=> !conv_run_bit_o) else $error("prohibited mode started");
	a_gate_run: assert property (gate_enable_sync_o |-> conv_run_bit_o)
		else $error("gate without run");
	a_done_pulse: assert property (conv_done_request_o |=> !conv_done_request_o)
		else $error("request too long");
	a_done_ends: assert property (conv_done_request_o |-> s_idle ##0
		$past(gate_enable_sync_o)) else $error("request without gated stop");
	a_ref_zero: assert property (conv_done_request_o |-> 24'h00_0000 ==
		(ref_counter_select_i ? counter_b_value_o : counter_a_value_o)) else $error("ref");
	a_hold_a: assert property (!conv_run_bit_o && !counter_a_load_i
		|=> $stable(counter_a_value_o)) else $error("counter a moved");
	a_chan_excl: assert property (!(osc_channel0_en_o && osc_channel1_en_o))
		else $error("both channels");
	a_osc_gated: assert property (osc_channel0_en_o || osc_channel1_en_o
		|-> gate_enable_sync_o) else $error("osc outside gate");
endmodule : rcadc_counters_chk
bind rcadc_counters rcadc_counters_chk u_chk (.*);

/* tb_rcadc_counters.sv */
// Self-checking testbench for the converter counting core.
`timescale 1ns/1ps
module tb_rcadc_counters;
	logic        clk, rst_n, base, rc, sel, set, clr, ld_a, ld_b, run, gate, done, ch0, ch1;
	logic        proh;
	logic [3:0]  mode;
	logic [1:0]  chan;
	logic [23:0] pre_a, pre_b, cnt_a, cnt_b;
	int          fails, tests_run, cyc;
	rcadc_counters u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .base_tick_clock_i(base),
		.rc_osc_clock_i(rc), .ref_counter_select_i(sel), .osc_mode_field_i(mode),
		.conv_run_set_i(set), .conv_run_clear_i(clr), .counter_a_load_i(ld_a),
		.counter_a_preset_i(pre_a), .counter_b_load_i(ld_b), .counter_b_preset_i(pre_b),
		.conv_run_bit_o(run), .gate_enable_sync_o(gate), .conv_done_request_o(done),
		.counter_a_value_o(cnt_a), .counter_b_value_o(cnt_b), .osc_channel0_en_o(ch0),
		.osc_channel1_en_o(ch1), .mode_prohibited_o(proh));
	// External-clock modes feed the counter from outside while gated.
	rcadc_osc_model u_osc (.en_i(ch0 | ch1 | (gate & (mode == 4'h0 || mode == 4'h7))),
		.clk_o(rc));
	initial begin clk = 1'b0; forever #5 clk = ~clk; end
	initial begin base = 1'b1; forever #40 base = ~base; end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (set) chan <= 2'b00;
		else if (gate) chan <= {ch1, ch0};
		if (cyc == 6000) begin fails++; wrap_up(); end
	end
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin fails++; $display("unexpected %0t: %h not %h", $time, seen, exp); end
	endtask : chk
	task conv(input logic s, input logic [3:0] m, input logic [23:0] a, input logic [23:0] b);
		@(negedge clk) {sel, mode, pre_a, pre_b, ld_a, ld_b} <= {s, m, a, b, 2'b11};
		@(negedge clk) {ld_a, ld_b, set} <= 3'b001;
		@(negedge clk) set <= 1'b0;
		for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
	endtask : conv
	task wrap_up;
		if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		{rst_n, sel, set, clr, ld_a, ld_b, mode, pre_a, pre_b} = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		conv(1'b0, 4'h1, 24'hFF_FFFA, 24'h00_0000);
		chk(done, 24'h00_0001);
		chk(cnt_a, 24'h00_0000);
		chk(cnt_b >= 24'h00_0006 && cnt_b <= 24'h00_000A, 24'h00_0001);
		chk(ch0 | ch1, 24'h00_0000);
		conv(1'b1, 4'h6, 24'h00_0000, 24'hFF_FFF8);
		chk(cnt_b, 24'h00_0000);
		chk(cnt_a >= 24'h00_0004 && cnt_a <= 24'h00_0008, 24'h00_0001);
		conv(1'b0, 4'h9, 24'hFF_FFFE, 24'h00_0000);
		chk(run, 24'h00_0000);
		chk(proh, 24'h00_0001);
		for (int m = 0; m < 8; m++) begin
			conv(1'b0, 4'(m), 24'hFF_FFFE, 24'h00_0000);
			chk(chan, (m == 0 || m == 7) ? 24'h00_0000 : (m < 5 ? 24'h00_0001 : 24'h00_0002));
		end
		chk(proh, 24'h00_0000);
		wrap_up();
	end
endmodule : tb_rcadc_counters
